/* File: design/synth_cfg_pkg.sv */
package synth_cfg_pkg;
	// Configuration register field positions
	localparam int CFG_POL_BIT = 7;
	localparam int CFG_DET_SEL_BIT = 6;
	localparam int CFG_LOCK_EN_BIT = 5;
	localparam int CFG_REF_SEL_HI = 4;
	localparam int CFG_REF_SEL_LO = 2;
	localparam int CFG_FV_EN_BIT = 1;
	localparam int CFG_FR_EN_BIT = 0;
	// Power-up value: reference divided by eight, everything else off
	localparam logic [7:0] CFG_RESET = 8'h10;
	localparam logic [15:0] DIVIDE_RESET = 16'h0000;
	// Transfer lengths that pick the destination register
	localparam logic [4:0] CFG_XFER_BITS = 5'h08;
	localparam logic [4:0] DIV_XFER_BITS = 5'h10;
	localparam logic [4:0] XFER_CNT_MAX = 5'h1F;
	// Reference output selector codes
	localparam logic [2:0] REF_SEL_OFF = 3'h0;
	localparam logic [2:0] REF_SEL_DIRECT = 3'h1;
	localparam logic [2:0] REF_SEL_DIV2 = 3'h2;
	localparam logic [2:0] REF_SEL_DIV4 = 3'h3;
	// Serial frame states, one bit changing per step except COMMIT back to IDLE
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_SHIFT = 2'h1,
		ST_COMMIT = 2'h3
	} xfer_state_t;
endpackage : synth_cfg_pkg

// Down counter with jam load; pulses for one cycle at the end of each period
module divide_counter
	import synth_cfg_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic jam_load,
	input wire logic [WIDTH-1:0] load_value,
	input wire logic count_step,
	output logic terminal_pulse
);
	logic [WIDTH-1:0] count_reg; // Remaining steps in this period
	wire at_end = (count_reg <= {{(WIDTH-1){1'b0}}, 1'b1}); // Also covers ratio 0 and 1

	// Jam load restarts the period at once, so old ratios never leak out
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			count_reg <= '0;
			terminal_pulse <= 1'b0;
		end else if (clk_en) begin
			terminal_pulse <= 1'b0;
			if (jam_load) begin
				count_reg <= load_value;
			end else if (count_step) begin
				count_reg <= at_end ? load_value : count_reg - 1'b1;
				terminal_pulse <= at_end;
			end
		end
	end
endmodule : divide_counter

/* File: design/synth_config_and_output_control.sv */
// Behaviour
// - Polarity bit inverts single output, swaps pair
// - Select high: single output on, pair high
// - Select low: pair on, single output floats
// - Lock output driven when enabled, else low
// - Three-bit code picks reference output divider
// - Power-up selects reference divided by eight
// - Each divided-output enable gates its own output
// - Power-up clears the other configuration bits
// - Eight-clock transfer loads configuration register only
// - Sixteen-clock transfer loads divide register only
// - Divide load jam-loads both counters together
// - Single output pulses on error, floats locked
// - Feedback leading gives low pulses, polarity low
// - Lock output high, low pulses on mismatch
module synth_config_and_output_control
	import synth_cfg_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic ser_enable_n,
	input wire logic reference_input,
	input wire logic feedback_input,
	input wire logic [14:0] ref_divide_value,
	output logic ref_out,
	output logic reference_divided_out,
	output logic feedback_divided_out,
	output logic single_ended_detector_out,
	output logic single_ended_detector_oe,
	output logic detector_r_out,
	output logic detector_v_out,
	output logic lock_indication_out,
	output logic [7:0] synth_configuration,
	output logic [15:0] feedback_divide
);
	// Serial shift side
	xfer_state_t state_reg, state_next;
	logic [15:0] shift_reg; // Last sixteen bits received, newest in bit 0
	logic [4:0] bit_cnt_reg; // Serial clocks seen in this frame, saturating
	logic ser_clk_prev; // For rising edge detection of the serial clock
	logic ref_prev; // Previous reference level for edge detection
	logic fb_prev; // Previous feedback level for edge detection
	logic [3:0] ref_div_reg; // Ripple-free binary divider of the reference
	logic up_reg; // Reference edge seen first: feedback lags
	logic down_reg; // Feedback edge seen first: feedback leads
	logic fr_pulse, fv_pulse; // Counter period ends

	// Decoding of the frame and events
	wire ser_rise = ser_clk & ~ser_clk_prev;
	wire ref_rise = reference_input & ~ref_prev;
	wire fb_rise = feedback_input & ~fb_prev;
	wire commit_cfg = (state_reg == ST_COMMIT) && (bit_cnt_reg == CFG_XFER_BITS);
	wire commit_div = (state_reg == ST_COMMIT) && (bit_cnt_reg == DIV_XFER_BITS);
	wire jam_load = commit_div;

	// Configuration fields
	wire detector_polarity = synth_configuration[CFG_POL_BIT];
	wire det_sel = synth_configuration[CFG_DET_SEL_BIT];
	wire lock_en = synth_configuration[CFG_LOCK_EN_BIT];
	wire [2:0] ref_sel = synth_configuration[CFG_REF_SEL_HI:CFG_REF_SEL_LO];
	wire fv_en = synth_configuration[CFG_FV_EN_BIT];
	wire fr_en = synth_configuration[CFG_FR_EN_BIT];

	// Reference output selection; codes 1xx fold onto eight and sixteen
	function automatic logic ref_pick(input logic [2:0] sel, input logic [3:0] div,
			input logic direct);
		logic pick;
		pick = 1'b0;
		case (sel)
			REF_SEL_OFF: pick = 1'b0;
			REF_SEL_DIRECT: pick = direct;
			REF_SEL_DIV2: pick = div[0];
			REF_SEL_DIV4: pick = div[1];
			default: pick = sel[0] ? div[3] : div[2];
		endcase
		return pick;
	endfunction : ref_pick

	// Detector error terms: only one side set means a real phase error
	wire err_up = up_reg & ~down_reg;
	wire err_down = down_reg & ~up_reg;
	wire pd_oe_next = det_sel & (err_up | err_down);
	wire pd_val_next = err_up ^ detector_polarity;
	wire v_low = detector_polarity ? up_reg : down_reg;
	wire r_low = detector_polarity ? down_reg : up_reg;
	wire lock_next = lock_en & ~(up_reg | down_reg);
	wire ref_next = ref_pick(ref_sel, ref_div_reg, ref_prev);

	// Frame sequencing: enable low opens a frame, rising enable ends it
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: state_next = ser_enable_n ? ST_IDLE : ST_SHIFT;
			ST_SHIFT: state_next = ser_enable_n ? ST_COMMIT : ST_SHIFT;
			ST_COMMIT: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	// Serial shifter, MSB first; count saturates so long frames never alias
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			shift_reg <= 16'h0000;
			bit_cnt_reg <= 5'h00;
			ser_clk_prev <= 1'b0;
		end else if (clk_en) begin
			state_reg <= state_next;
			ser_clk_prev <= ser_clk;
			if (state_reg == ST_IDLE) begin
				bit_cnt_reg <= 5'h00;
			end else if (state_reg == ST_SHIFT && ser_rise && !ser_enable_n) begin
				shift_reg <= {shift_reg[14:0], ser_data};
				if (bit_cnt_reg != XFER_CNT_MAX) begin
					bit_cnt_reg <= bit_cnt_reg + 5'h01;
				end
			end
		end
	end

	// Register file; odd frame lengths leave both registers alone
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			synth_configuration <= CFG_RESET;
			feedback_divide <= DIVIDE_RESET;
		end else if (clk_en) begin
			if (commit_cfg) begin
				synth_configuration <= shift_reg[7:0];
			end
			if (commit_div) begin
				feedback_divide <= shift_reg;
			end
		end
	end

	// Reference edges feed the output divider
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ref_prev <= 1'b0;
			fb_prev <= 1'b0;
			ref_div_reg <= 4'h0;
		end else if (clk_en) begin
			ref_prev <= reference_input;
			fb_prev <= feedback_input;
			if (ref_rise) begin
				ref_div_reg <= ref_div_reg + 4'h1;
			end
		end
	end

	// Both counters share the jam strobe so they restart in step
	divide_counter #(.WIDTH(15)) u_ref_counter (
		.sys_clk(sys_clk),
		.rst(rst),
		.clk_en(clk_en),
		.jam_load(jam_load),
		.load_value(ref_divide_value),
		.count_step(ref_rise),
		.terminal_pulse(fr_pulse)
	);
	// The divide register only takes the new word at this very edge, so the jam
	// must use the shifter's copy or the counter would restart on the old ratio
	wire [15:0] fb_jam_value = jam_load ? shift_reg : feedback_divide;

	divide_counter #(.WIDTH(16)) u_fb_counter (
		.sys_clk(sys_clk),
		.rst(rst),
		.clk_en(clk_en),
		.jam_load(jam_load),
		.load_value(fb_jam_value),
		.count_step(fb_rise),
		.terminal_pulse(fv_pulse)
	);

	// Phase detector; jam clears it, and both set clears it after one cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			up_reg <= 1'b0;
			down_reg <= 1'b0;
		end else if (clk_en) begin
			if (jam_load || (up_reg && down_reg)) begin
				up_reg <= 1'b0;
				down_reg <= 1'b0;
			end else begin
				up_reg <= up_reg | fr_pulse;
				down_reg <= down_reg | fv_pulse;
			end
		end
	end

	// All pin-facing outputs come from flops to keep them glitch free
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ref_out <= 1'b0;
			reference_divided_out <= 1'b0;
			feedback_divided_out <= 1'b0;
			single_ended_detector_out <= 1'b0;
			single_ended_detector_oe <= 1'b0;
			detector_r_out <= 1'b1;
			detector_v_out <= 1'b1;
			lock_indication_out <= 1'b0;
		end else if (clk_en) begin
			ref_out <= ref_next;
			reference_divided_out <= fr_en & fr_pulse;
			feedback_divided_out <= fv_en & fv_pulse;
			single_ended_detector_out <= pd_val_next;
			single_ended_detector_oe <= pd_oe_next;
			detector_r_out <= det_sel | ~r_low;
			detector_v_out <= det_sel | ~v_low;
			lock_indication_out <= lock_next;
		end
	end

	// Checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	a_config_load_byte: assert property (clk_en && commit_cfg |=>
		synth_configuration == $past(shift_reg[7:0]) && $stable(feedback_divide))
		else $error("configuration byte not stored");
	a_divide_load_word: assert property (clk_en && commit_div |=>
		feedback_divide == $past(shift_reg) && $stable(synth_configuration))
		else $error("divide word not stored");
	a_jam_clears_detector: assert property (clk_en && commit_div |=>
		!up_reg && !down_reg)
		else $error("jam did not clear detector");
	a_power_up_config: assert property ($fell(rst) |->
		synth_configuration == 8'h10)
		else $error("power-up configuration wrong");
	a_lock_gated_low: assert property (clk_en && !lock_en |=> !lock_indication_out)
		else $error("lock output not held low");
	a_pair_held_high: assert property (clk_en && det_sel |=>
		detector_r_out && detector_v_out)
		else $error("detector pair not held high");
	a_single_floats: assert property (clk_en && !det_sel |=>
		!single_ended_detector_oe)
		else $error("single detector output driven");
	a_lead_low_pulse: assert property (clk_en && det_sel && !detector_polarity && err_down |=>
		single_ended_detector_oe && !single_ended_detector_out)
		else $error("leading feedback not a low pulse");
	a_pol_swaps_pair: assert property (clk_en && !det_sel && detector_polarity && err_up |=>
		!detector_v_out && detector_r_out)
		else $error("polarity did not swap pair");
	a_fv_gate_low: assert property (clk_en && !fv_en |=> !feedback_divided_out)
		else $error("feedback divided output not gated");
	a_ref_static_low: assert property (clk_en && ref_sel == REF_SEL_OFF |=> !ref_out)
		else $error("reference output not static low");

	c_config_write: cover property (clk_en && commit_cfg);
	c_divide_write: cover property (clk_en && commit_div);
	c_single_pulse: cover property (single_ended_detector_oe ##1 !single_ended_detector_oe);
	c_lock_dip: cover property (lock_en && lock_indication_out ##1 !lock_indication_out);
endmodule : synth_config_and_output_control

/* File: verification/host_serial_model.sv */
// Host side of the serial load port; every transfer is framed by enable
module host_serial_model (
	input wire logic sys_clk,
	output logic ser_clk,
	output logic ser_data,
	output logic ser_enable_n
);
	timeunit 1ns;
	timeprecision 1ps;

	// Clock held low from time zero, so the power-up reset alone initialises
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		ser_enable_n = 1'b1;
	end

	// Clock stays low a few cycles after enable falls, so no edge is lost
	task open_frame();
		@(posedge sys_clk);
		ser_enable_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask : open_frame

	// Data settles a cycle ahead of the rising clock and holds through it
	task put_bit(input logic b);
		ser_data <= b;
		@(posedge sys_clk);
		ser_clk <= 1'b1;
		repeat (2) @(posedge sys_clk);
		ser_clk <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask : put_bit

	// Released data line flips rather than keeping a stale value
	task close_frame();
		ser_enable_n <= 1'b1;
		ser_data <= ~ser_data;
		repeat (6) @(posedge sys_clk);
	endtask : close_frame

	// Eight-clock frame, first bit is the top bit
	task send_byte(input logic [7:0] v);
		open_frame();
		for (int i = 7; i >= 0; i--) put_bit(v[i]);
		close_frame();
	endtask : send_byte

	// Sixteen-clock frame, first bit is the top bit
	task send_word(input logic [15:0] v);
		open_frame();
		for (int i = 15; i >= 0; i--) put_bit(v[i]);
		close_frame();
	endtask : send_word
endmodule : host_serial_model

/* File: verification/tb_synth_config_and_output_control.sv */
module tb_synth_config_and_output_control;
	timeunit 1ns;
	timeprecision 1ps;

	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en; // Lowered once to show that the configuration, ref_out and lock output hold
	logic ser_clk, ser_data, ser_enable_n;
	logic reference_input;
	logic feedback_input;
	logic [14:0] ref_divide_value;
	logic ref_out, reference_divided_out, feedback_divided_out;
	logic single_ended_detector_out, single_ended_detector_oe;
	logic detector_r_out, detector_v_out, lock_indication_out;
	logic [7:0] synth_configuration;
	logic [15:0] feedback_divide;
	logic ref_prev;
	int num_errors = 0;
	int checked = 0;
	int ref_half = 2; // Reference period is four clocks
	int fb_half = 1; // Feedback runs twice as fast: out of lock
	bit fb_same = 1'b0; // When set, feedback copies the reference exactly
	int ph_r = 0;
	int ph_f = 0;
	int c_ref, c_rd, c_fd, c_lock, c_oe, c_lo, c_hi, c_r, c_v, c_mis;

	host_serial_model i_host (.sys_clk, .ser_clk, .ser_data, .ser_enable_n);

	synth_config_and_output_control i_dut (
		.sys_clk, .rst, .clk_en, .ser_clk, .ser_data, .ser_enable_n,
		.reference_input, .feedback_input, .ref_divide_value, .ref_out,
		.reference_divided_out, .feedback_divided_out, .single_ended_detector_out,
		.single_ended_detector_oe, .detector_r_out, .detector_v_out,
		.lock_indication_out, .synth_configuration, .feedback_divide
	);

	always #2 sys_clk = ~sys_clk;

	// Square waves on both loop inputs
	always @(posedge sys_clk) begin
		ph_r = (ph_r + 1 >= ref_half) ? 0 : ph_r + 1;
		ph_f = (ph_f + 1 >= fb_half) ? 0 : ph_f + 1;
		if (ph_r == 0) reference_input <= ~reference_input;
		if (fb_same) feedback_input <= (ph_r == 0) ? ~reference_input : reference_input;
		else if (ph_f == 0) feedback_input <= ~feedback_input;
	end

	task check(input bit ok, input string what);
		checked++;
		if (!ok) begin
			num_errors++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask : check

	// Tally output activity over a window of clocks
	task watch(input int n);
		{c_ref, c_rd, c_fd, c_lock, c_oe, c_lo, c_hi, c_r, c_v, c_mis} = '0;
		ref_prev = ref_out;
		repeat (n) begin
			@(posedge sys_clk);
			c_ref += (ref_out === 1'b1 && ref_prev === 1'b0);
			ref_prev = ref_out;
			c_rd += (reference_divided_out === 1'b1);
			c_fd += (feedback_divided_out === 1'b1);
			c_mis += (reference_divided_out !== feedback_divided_out);
			c_lock += (lock_indication_out === 1'b1);
			c_oe += (single_ended_detector_oe === 1'b1);
			c_lo += (single_ended_detector_oe === 1'b1 && single_ended_detector_out === 1'b0);
			c_hi += (single_ended_detector_oe === 1'b1 && single_ended_detector_out === 1'b1);
			c_r += (detector_r_out !== 1'b1);
			c_v += (detector_v_out !== 1'b1);
		end
	endtask : watch

	task t_reset();
		check(synth_configuration === 8'h10, "config after reset");
		check(feedback_divide === 16'h0000 && lock_indication_out === 1'b0, "lock");
		check(single_ended_detector_oe === 1'b0 && detector_r_out === 1'b1, "pins");
	endtask : t_reset

	// Every selector code, rate measured against 64 reference edges
	task automatic t_ref_decode();
		int exp;
		int divs[8] = '{0, 1, 2, 4, 8, 16, 8, 16};
		for (int c = 0; c < 8; c++) begin
			i_host.send_byte({3'b000, c[2:0], 2'b00});
			check(synth_configuration === {3'b000, c[2:0], 2'b00}
				&& feedback_divide === 16'h0000, "byte load");
			watch(256);
			exp = (divs[c] == 0) ? 0 : 64 / divs[c];
			check(c_ref >= exp - 1 && c_ref <= exp + 1, "ref output rate");
		end
	endtask : t_ref_decode

	task t_gates();
		i_host.send_byte(8'h11);
		watch(256);
		check(c_rd > 0 && c_fd == 0, "reference gate");
		i_host.send_byte(8'h12);
		watch(256);
		check(c_rd == 0 && c_fd > 0, "feedback gate");
	endtask : t_gates

	// Feedback leads, then lags; polarity and selector walked through all four pairs
	// A lagging feedback flips the expected sense, just as the polarity bit does
	task t_detector();
		for (int k = 0; k < 8; k++) begin
			fb_half <= k[2] ? 4 : 1;
			i_host.send_byte({k[0], k[1], k[1], 5'b10000});
			watch(256);
			if (k[1]) begin
				check(c_r == 0 && c_v == 0 && c_oe > 0, "select high");
				check(c_lock > 0 && c_lock < 256, "lock pulses");
				check((k[0] ^ k[2]) ? c_hi > c_lo : c_lo > c_hi, "single polarity");
			end else begin
				check(c_oe == 0 && c_lock == 0, "select low");
				check((k[0] ^ k[2]) ? c_r > c_v : c_v > c_r, "pair polarity");
			end
		end
	endtask : t_detector

	// Load the divide while counters are out of step, then a twelve-clock frame
	task t_jam();
		i_host.send_byte(8'h73);
		ref_divide_value <= 15'h0006;
		fb_same <= 1'b1;
		i_host.send_word(16'h0006);
		check(feedback_divide === 16'h0006 && synth_configuration === 8'h73, "word");
		watch(512);
		check(c_mis == 0 && c_rd > 0, "counters in step");
		check(c_oe * 8 < 512 && c_lock * 2 > 512, "locked");
		i_host.open_frame();
		for (int i = 0; i < 12; i++) i_host.put_bit(1'b1);
		i_host.close_frame();
		check(feedback_divide === 16'h0006 && synth_configuration === 8'h73, "odd");
	endtask : t_jam

	// Freeze the block, send a frame meanwhile, then show that loading works again
	task t_freeze();
		logic [9:0] hold;
		@(posedge sys_clk);
		clk_en <= 1'b0;
		@(posedge sys_clk);
		hold = {synth_configuration, ref_out, lock_indication_out};
		i_host.send_byte(8'h00);
		check(hold === {synth_configuration, ref_out, lock_indication_out}, "frozen");
		@(posedge sys_clk);
		clk_en <= 1'b1;
		i_host.send_byte(8'h10);
		check(synth_configuration === 8'h10, "load after freeze");
	endtask : t_freeze

	task wrap_up();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up

	initial begin
		clk_en = 1'b1;
		reference_input = 1'b0;
		feedback_input = 1'b0;
		ref_divide_value = 15'h0004;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_reset();
		t_ref_decode();
		t_gates();
		i_host.send_word(16'h0004);
		t_detector();
		t_jam();
		t_freeze();
		wrap_up();
	end

	// Whole run needs well under ten thousand clocks
	initial begin
		repeat (40000) @(posedge sys_clk);
		num_errors++;
		wrap_up();
	end
endmodule : tb_synth_config_and_output_control
